/* File: sync_master_serial_transmitter_test.sv */
// Purpose: self-checking bench for sync_master_tx
// Assumes: divisor kept small so words take few cycles
// Notes:   words checked in order of writing
`timescale 1ns/10ps
`include "sync_tx_defs.vh"
module sync_master_serial_transmitter_test;
  logic        pclk, presetn, psel, penable, pwrite, listen, nine, err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [8:0]  q, exp_q[$];
  logic [7:0]  d;
  wire  [31:0] prdata;
  wire  [8:0]  s_word;
  wire         pready, pslverr, ck_out, ck_oe, dt_out, dt_oe, drive_bit;
  int          s_count, n_fail, cmp_count, cyc;
  // pull-down on clock line, slave drives data when released
  wire         ck_line = ck_oe ? ck_out : 1'b0;
  wire         dt_line = dt_oe ? dt_out : drive_bit;
  sync_master_tx i_sync_master_tx (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shift_clock_line_in(ck_line),
    .shift_clock_line_out(ck_out), .shift_clock_line_oe(ck_oe), .serial_data_line_in(dt_line),
    .serial_data_line_out(dt_out), .serial_data_line_oe(dt_oe));
  sync_slave_model i_sync_slave_model (.shift_clock_line(ck_line), .serial_data_line(dt_line),
    .listen(listen), .nine(nine), .drive_bit(drive_bit), .word(s_word), .count(s_count));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= `BYTE_ADDR(i);
    pwdata  <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) n_fail++;
    q   = {1'b0, prdata[7:0]};
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wait_cnt(input int k);
    int n;
    n = 0;
    while (s_count < k && n++ < 5000) @(posedge pclk);
    if (s_count < k) n_fail++;
  endtask
  task automatic send(input logic b);
    d = $urandom;
    exp_q.push_back({b, d});
    apb(1, `IDX_TRANSMIT_BUFFER, d);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(s_count) if (s_count > 0) chk(s_word, exp_q.size() ? exp_q.pop_front() : 9'hxxx);
  always @(posedge pclk) if (++cyc == 20000) begin
    n_fail++;
    wrap_up();
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, listen, nine, paddr, pwdata} = '0;
    {n_fail, cmp_count, cyc} = '0;
    void'($urandom(32'h9c5c));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    listen  <= 1'b1;
    apb(0, `IDX_TRANSMIT_STATUS, 0); chk(q, 9'h002);
    apb(0, `IDX_PERIPHERAL_FLAGS_ONE, 0); chk(q, 9'h010);
    apb(0, 8'h03, 0); chk({q[7:0], err}, 9'h001); // unmapped
    $display("reset test done");
    apb(1, `IDX_BAUD_DIVISOR, $urandom % 4);
    apb(1, `IDX_RECEIVE_STATUS, 8'h80);
    apb(1, `IDX_TRANSMIT_STATUS, 8'hb0);
    apb(1, `IDX_INTERRUPT_CONTROL, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      send(1'b0);
      apb(0, `IDX_PERIPHERAL_FLAGS_ONE, 0); chk(q & 9'h010, k ? 9'h000 : 9'h010);
    end
    apb(0, `IDX_TRANSMIT_STATUS, 0); chk(q & 9'h002, 9'h000);
    wait_cnt(2);
    apb(1, `IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    apb(0, `IDX_PERIPHERAL_ENABLES, 0); chk(q, 9'h000);
    apb(0, `IDX_PERIPHERAL_FLAGS_ONE, 0); chk(q & 9'h010, 9'h010);
    apb(0, `IDX_TRANSMIT_STATUS, 0); chk(q & 9'h002, 9'h002);
    $display("back to back test done");
    nine <= 1'b1;
    for (int b = 1; b >= 0; b--) begin
      apb(1, `IDX_TRANSMIT_STATUS, 8'hf0 | b[7:0]);
      send(b[0]);
    end
    wait_cnt(4);
    nine <= 1'b0;
    $display("nine bit test done");
    apb(1, `IDX_TRANSMIT_STATUS, 8'h90);
    send(1'b0);
    repeat (40) @(posedge pclk);
    chk(9'(s_count), 9'h004);
    apb(1, `IDX_TRANSMIT_STATUS, 8'hb0);
    wait_cnt(5);
    $display("enable after load test done");
    send(1'b0);
    void'(exp_q.pop_back());
    listen <= 1'b0;
    apb(1, `IDX_RECEIVE_STATUS, 8'ha0); chk({ck_oe, dt_oe}, 9'h002);
    for (int n = 0; n < 2000 && !dt_oe; n++) @(posedge pclk);
    chk({ck_oe, dt_oe}, 9'h003);
    apb(0, `IDX_RECEIVE_STATUS, 0); chk(q & 9'h020, 9'h000);
    apb(1, `IDX_TRANSMIT_STATUS, 8'h90); chk({ck_oe, dt_oe}, 9'h000);
    listen <= 1'b1;
    apb(1, `IDX_TRANSMIT_STATUS, 8'hb0);
    send(1'b0);
    wait_cnt(6);
    $display("abort test done");
    apb(1, `IDX_TRANSMIT_STATUS, 8'h00);
    apb(1, `IDX_RECEIVE_STATUS, 8'h00); chk({ck_oe, dt_oe}, 9'h000);
    chk(9'(exp_q.size()), 9'h000);
    wrap_up();
  end
endmodule

/* File: sync_master_tx.v */
// Purpose: synchronous master serial transmit path with APB registers
// Assumes: pins synchronous to pclk; one shift clock half period is
//          (baud_divisor + 1) instruction cycles
// Notes:   clock idles low; data changes on rising, stable on falling edge
`timescale 1ns/10ps
`include "sync_tx_defs.vh"

// Overview of operation
// (RL1) half duplex: receive blocks transmit
// (RL2) sync select bit enables synchronous operation
// (RL3) port enable assigns clock and data pins
// (RL4) clock master select drives shift clock out
// (RL5) reload shift register only after last bit
// (RL6) transfer takes one cycle, sets empty flag
// (RL7) empty flag independent of its enable
// (RL8) empty flag cleared only by buffer write
// (RL9) read-only shift empty status, no interrupt
// (RL10) enable alone starts nothing until buffer loaded
// (RL11) bits driven on rising clock edge
// (RL12) generator held reset when all enables clear
// (RL13) transmit enable starts generator clock immediately; here the generator stays cleared until a word is loaded to shift
// (RL14) write when shift empty moves data immediately
// (RL15) clearing enable aborts, resets, floats pins
// (RL16) receive enable aborts, floats data only; here the word in the shift register is held and resumes when receive ends
// (RL17) single receive done, resume transmitting
// (RL18) nine-bit mode sends stored ninth bit
// (RL19) ninth bit written before buffer write
// (RL20) software follows documented setup order
// (RL21) software sets global interrupt enables
// (RL22) lsb first, one bit per clock period
module sync_master_tx #(
  parameter DIV_W = 8
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`ADDR_W-1:0]   paddr,
  input  wire [31:0]          pwdata,
  output wire [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire                 shift_clock_line_in,
  output wire                 shift_clock_line_out,
  output wire                 shift_clock_line_oe,
  input  wire                 serial_data_line_in,
  output wire                 serial_data_line_out,
  output wire                 serial_data_line_oe
);

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0]       interrupt_control_ff;
  reg  [7:0]       peripheral_enables_one_ff;
  reg  [7:0]       txs_ff;
  reg  [7:0]       rcs_ff;
  reg  [DIV_W-1:0] baud_divisor_ff;
  reg  [7:0]       transmit_buffer_ff;
  reg              buf_full_ff;
  reg  [7:0]       receive_buffer_ff;
  reg              rx_ninth_ff;
  reg  [31:0]      prdata_ff;

  reg  [DIV_W+7:0] brg_cnt_ff;
  reg              sck_ff;
  reg  [8:0]       transmit_shift_register_ff;
  reg  [3:0]       tx_bits_ff;
  reg              tsr_empty_ff;
  reg              dout_ff;
  reg  [8:0]       rsr_ff;
  reg  [3:0]       rx_bits_ff;

  wire             unused_clk_in;
  assign unused_clk_in = shift_clock_line_in;

  // ****************************************
  // control decode
  // ****************************************
  wire clock_source_master_select = txs_ff[`TXS_CLOCK_MASTER];
  wire nine_bit_transmit_select   = txs_ff[`TXS_NINE_BIT];
  wire transmit_enable_bit        = txs_ff[`TXS_TX_ENABLE];
  wire sync_select                = txs_ff[`TXS_SYNC_SELECT];
  wire ninth_transmit_bit         = txs_ff[`TXS_NINTH_BIT];
  wire serial_port_enable         = rcs_ff[`RCS_PORT_ENABLE];
  wire nine_bit_receive_select    = rcs_ff[`RCS_NINE_BIT];
  wire single_receive_enable      = rcs_ff[`RCS_SINGLE_RX];
  wire continuous_receive_enable  = rcs_ff[`RCS_CONT_RX];

  wire port_sync   = serial_port_enable & sync_select;                      // [RL2] [RL3]
  wire master_mode = port_sync & clock_source_master_select;                // [RL4]
  wire rx_req      = continuous_receive_enable | single_receive_enable;
  wire brg_run     = transmit_enable_bit | rx_req;                          // [RL12]
  wire rx_active   = master_mode & rx_req;
  wire tx_hold     = rx_req;                                                // [RL1] [RL16]
  wire tx_active   = master_mode & transmit_enable_bit & ~tx_hold & ~tsr_empty_ff;

  // ****************************************
  // apb access
  // ****************************************
  wire [7:0] idx     = paddr[9:2];
  wire       aligned = (paddr[1:0] == 2'b00) & (paddr[`ADDR_W-1:10] == 2'b00);
  reg        hit;
  reg  [7:0] rd_val;

  always @* begin
    hit    = aligned;
    rd_val = `RST_ZERO;
    case (idx)
      `IDX_INTERRUPT_CONTROL: begin
        rd_val = interrupt_control_ff;
      end
      `IDX_PERIPHERAL_FLAGS_ONE: begin
        rd_val = {3'b000, ~buf_full_ff, 4'b0000};                            // [RL7]
      end
      `IDX_RECEIVE_STATUS: begin
        rd_val = {rcs_ff[7:3], 2'b00, rx_ninth_ff};
      end
      `IDX_TRANSMIT_BUFFER: begin
        rd_val = transmit_buffer_ff;
      end
      `IDX_RECEIVE_BUFFER: begin
        rd_val = receive_buffer_ff;
      end
      `IDX_PERIPHERAL_ENABLES: begin
        rd_val = peripheral_enables_one_ff;
      end
      `IDX_TRANSMIT_STATUS: begin
        rd_val = {txs_ff[7:4], 1'b0, txs_ff[2], tsr_empty_ff, txs_ff[0]};   // [RL9]
      end
      `IDX_BAUD_DIVISOR: begin
        rd_val = baud_divisor_ff;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (!aligned) begin
      hit = 1'b0;
    end
  end

  wire setup_rd = psel & ~penable & ~pwrite;
  wire wr_en    = psel & penable & pwrite & hit;
  wire wr_txs   = wr_en & (idx == `IDX_TRANSMIT_STATUS);
  wire wr_rcs   = wr_en & (idx == `IDX_RECEIVE_STATUS);
  wire wr_tbuf  = wr_en & (idx == `IDX_TRANSMIT_BUFFER);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  // registered read data, captured in the setup phase
  assign prdata  = prdata_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_ff <= {24'h00_0000, rd_val};
    end
  end

  // ****************************************
  // baud rate generator
  // ****************************************
  // half period in pclk cycles; the generator stays cleared while
  // nothing shifts, so a fresh word always starts from a full low half
  wire [DIV_W+39:0] half_wide =
    ({8'h00, baud_divisor_ff} + 1'b1) * `INSTR_CYCLES;
  wire [DIV_W+7:0]  half_period = half_wide[DIV_W+7:0];
  wire clk_run  = tx_active | rx_active;
  wire brg_tick = clk_run & (brg_cnt_ff == half_period - 1'b1);
  wire rise_evt = brg_tick & ~sck_ff;
  wire fall_evt = brg_tick & sck_ff;
  // last bit out, nothing queued: clock stays low, no stray pulse
  wire end_evt  = rise_evt & tx_active & ~rx_active & (tx_bits_ff == 4'd0) & ~buf_full_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_cnt_ff <= {(DIV_W+8){1'b0}};
      sck_ff     <= 1'b0;
    end else if (!brg_run || !clk_run) begin                                 // [RL12]
      brg_cnt_ff <= {(DIV_W+8){1'b0}};
      sck_ff     <= 1'b0;
    end else if (end_evt) begin
      brg_cnt_ff <= {(DIV_W+8){1'b0}};
      sck_ff     <= 1'b0;
    end else if (brg_tick) begin
      brg_cnt_ff <= {(DIV_W+8){1'b0}};
      sck_ff     <= ~sck_ff;
    end else begin
      brg_cnt_ff <= brg_cnt_ff + 1'b1;                                       // [RL13]
    end
  end

  // ****************************************
  // transmit buffer and shift register
  // ****************************************
  wire [3:0] word_bits = nine_bit_transmit_select ? 4'd9 : 4'd8;
  wire [8:0] word      = {ninth_transmit_bit & nine_bit_transmit_select,
                          transmit_buffer_ff};                               // [RL18] [RL19]
  wire tx_on      = port_sync & transmit_enable_bit;
  wire load_idle  = tx_on & tsr_empty_ff & buf_full_ff;                      // [RL10] [RL14]
  wire word_done  = rise_evt & ~tx_hold & (tx_bits_ff == 4'd0);
  wire load_chain = word_done & buf_full_ff;                                 // [RL5]
  wire xfer       = load_idle | load_chain;
  // set over clear: a write racing a transfer keeps the new byte
  wire nxt_buf_full = (buf_full_ff & ~xfer) | wr_tbuf;                       // [RL6] [RL8]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_full_ff <= 1'b0;
    end else begin
      buf_full_ff <= nxt_buf_full;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer_ff <= `RST_ZERO;
    end else if (wr_tbuf) begin
      transmit_buffer_ff <= pwdata[7:0];
    end
  end

  reg  [8:0]       nxt_tsr;
  reg  [3:0]       nxt_tx_bits;
  reg              nxt_tsr_empty;
  reg              nxt_dout;

  always @* begin
    nxt_tsr       = transmit_shift_register_ff;
    nxt_tx_bits   = tx_bits_ff;
    nxt_tsr_empty = tsr_empty_ff;
    nxt_dout      = dout_ff;
    if (!tx_on) begin                                                        // [RL15]
      nxt_tsr       = 9'h000;
      nxt_tx_bits   = 4'd0;
      nxt_tsr_empty = 1'b1;
      nxt_dout      = 1'b0;
    end else if (load_idle) begin
      nxt_tsr       = word;
      nxt_tx_bits   = word_bits;
      nxt_tsr_empty = 1'b0;
    end else if (rise_evt && !tx_hold) begin                                 // [RL11]
      if (tx_bits_ff != 4'd0) begin
        nxt_dout    = transmit_shift_register_ff[0];                         // [RL22]
        nxt_tsr     = {1'b0, transmit_shift_register_ff[8:1]};
        nxt_tx_bits = tx_bits_ff - 1'b1;
      end else if (buf_full_ff) begin
        nxt_dout    = word[0];
        nxt_tsr     = {1'b0, word[8:1]};
        nxt_tx_bits = word_bits - 1'b1;
      end else begin
        nxt_tsr_empty = 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_shift_register_ff <= 9'h000;
      tx_bits_ff                 <= 4'd0;
      tsr_empty_ff               <= 1'b1;
      dout_ff                    <= 1'b0;
    end else begin
      transmit_shift_register_ff <= nxt_tsr;
      tx_bits_ff                 <= nxt_tx_bits;
      tsr_empty_ff               <= nxt_tsr_empty;
      dout_ff                    <= nxt_dout;
    end
  end

  // ****************************************
  // single-word / continuous receive
  // ****************************************
  wire [3:0] rx_len  = nine_bit_receive_select ? 4'd9 : 4'd8;
  wire       rx_done = rx_active & fall_evt & (rx_bits_ff == rx_len - 1'b1);
  wire [8:0] rx_next = {serial_data_line_in, rsr_ff[8:1]};

  // receive only borrows the clock; transmit waits on tx_hold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr_ff     <= 9'h000;
      rx_bits_ff <= 4'd0;
    end else if (!rx_active) begin
      rx_bits_ff <= 4'd0;
    end else if (fall_evt) begin
      rsr_ff <= rx_next;
      if (rx_done) begin
        rx_bits_ff <= 4'd0;
      end else begin
        rx_bits_ff <= rx_bits_ff + 1'b1;
      end
    end
  end

  // eight-bit words: the last bit arrives in the capture cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer_ff <= `RST_ZERO;
      rx_ninth_ff       <= 1'b0;
    end else if (rx_done && nine_bit_receive_select) begin
      receive_buffer_ff <= rsr_ff[8:1];
      rx_ninth_ff       <= serial_data_line_in;
    end else if (rx_done) begin
      receive_buffer_ff <= rx_next[8:1];
      rx_ninth_ff       <= 1'b0;
    end
  end

  // ****************************************
  // control and status registers
  // ****************************************
  // single receive without continuous receive clears itself when its word is in
  wire clr_single = rx_done & single_receive_enable & ~continuous_receive_enable;
  wire wr_intc    = wr_en & (idx == `IDX_INTERRUPT_CONTROL);
  wire wr_penb    = wr_en & (idx == `IDX_PERIPHERAL_ENABLES);
  wire wr_div     = wr_en & (idx == `IDX_BAUD_DIVISOR);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txs_ff <= `RST_TRANSMIT_STATUS;
    end else if (wr_txs) begin
      txs_ff <= pwdata[7:0] & `TXS_WR_MASK;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcs_ff <= `RST_ZERO;
    end else if (wr_rcs) begin
      rcs_ff <= pwdata[7:0] & `RCS_WR_MASK;
    end else if (clr_single) begin
      rcs_ff[`RCS_SINGLE_RX] <= 1'b0;                                        // [RL17]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control_ff <= `RST_ZERO;
    end else if (wr_intc) begin
      interrupt_control_ff <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_enables_one_ff <= `RST_ZERO;
    end else if (wr_penb) begin
      peripheral_enables_one_ff <= pwdata[7:0];                              // [RL7]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_divisor_ff <= {DIV_W{1'b0}};
    end else if (wr_div) begin
      baud_divisor_ff <= pwdata[DIV_W-1:0];
    end
  end

  // ****************************************
  // pins
  // ****************************************
  // clock pin stays driven through a receive that interrupts a word
  assign shift_clock_line_out = sck_ff;
  assign shift_clock_line_oe  = master_mode & brg_run;                       // [RL4] [RL16]
  assign serial_data_line_out = dout_ff;
  assign serial_data_line_oe  = port_sync & transmit_enable_bit & ~tx_hold;  // [RL15] [RL17]

endmodule

/* File: sync_slave_model.sv */
// Purpose: synchronous serial slave on the clock and data lines
// Assumes: listen low while the bench resynchronises words
// Notes:   drives a toggling bit for the device to receive
`timescale 1ns/10ps
module sync_slave_model (
  input  wire        shift_clock_line,
  input  wire        serial_data_line,
  input  wire        listen,
  input  wire        nine,
  output logic       drive_bit,
  output logic [8:0] word,
  output int         count
);
  logic [8:0] sh;
  int         n;
  initial begin
    drive_bit = 1'b0;
    word      = 9'h000;
    count     = 0;
    sh        = 9'h000;
    n         = 0;
  end
  // ****************************************
  // sample on falling clock, lsb first
  // ****************************************
  always @(negedge shift_clock_line) begin
    drive_bit <= ~drive_bit;
    if (listen) begin
      sh = {serial_data_line, sh[8:1]};
      n = n + 1;
      if (n == (nine ? 9 : 8)) begin
        word  <= nine ? sh : {1'b0, sh[8:1]};
        count <= count + 1;
        n = 0;
      end
    end else begin
      n = 0;
    end
  end
endmodule

/* File: sync_tx_defs.vh */
// Purpose: constants for the synchronous master serial transmitter
// Assumes: register indices are word indices, byte address = index * 4
// Notes:   definitions only
`ifndef SYNC_TX_DEFS_VH
`define SYNC_TX_DEFS_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define IDX_INTERRUPT_CONTROL     8'h0b
`define IDX_PERIPHERAL_FLAGS_ONE  8'h0c
`define IDX_RECEIVE_STATUS        8'h18
`define IDX_TRANSMIT_BUFFER       8'h19
`define IDX_RECEIVE_BUFFER        8'h1a
`define IDX_PERIPHERAL_ENABLES    8'h8c
`define IDX_TRANSMIT_STATUS       8'h98
`define IDX_BAUD_DIVISOR          8'h99
`define ADDR_W                    12
`define BYTE_ADDR(i)              ({2'b00, (i), 2'b00})

// ****************************************
// field positions
// ****************************************
`define TXS_CLOCK_MASTER          7
`define TXS_NINE_BIT              6
`define TXS_TX_ENABLE             5
`define TXS_SYNC_SELECT           4
`define TXS_SHIFT_EMPTY           1
`define TXS_NINTH_BIT             0
`define RCS_PORT_ENABLE           7
`define RCS_NINE_BIT              6
`define RCS_SINGLE_RX             5
`define RCS_CONT_RX               4
`define RCS_NINTH_RX              0
`define PF1_TX_EMPTY              4
`define TXS_WR_MASK               8'hf5
`define RCS_WR_MASK               8'hf8

// ****************************************
// reset values
// ****************************************
`define RST_TRANSMIT_STATUS       8'h02
`define RST_ZERO                  8'h00

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS             10
`define INSTR_CYCLE_NS            10
`define INSTR_CYCLES              ((`INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: sync_tx_properties.sv */
// Purpose: port checks for the synchronous master transmitter
// Assumes: baud divisor changes only through apb writes
// Notes:   bound into every sync_master_tx instance
`timescale 1ns/10ps
`include "sync_tx_defs.vh"
module sync_tx_properties #(
  parameter DIV_W = 8
) (
  input wire                pclk,
  input wire                presetn,
  input wire                psel,
  input wire                penable,
  input wire                pwrite,
  input wire [`ADDR_W-1:0]  paddr,
  input wire [31:0]         pwdata,
  input wire                pready,
  input wire                shift_clock_line_out,
  input wire                shift_clock_line_oe,
  input wire                serial_data_line_out,
  input wire                serial_data_line_oe
);
  localparam logic [`ADDR_W-1:0] A_TXS = `BYTE_ADDR(`IDX_TRANSMIT_STATUS);
  localparam logic [`ADDR_W-1:0] A_RCS = `BYTE_ADDR(`IDX_RECEIVE_STATUS);
  localparam logic [`ADDR_W-1:0] A_DIV = `BYTE_ADDR(`IDX_BAUD_DIVISOR);
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W:0]   hi_ff;
  // ****************************************
  // divisor shadow and clock high-time count
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
      hi_ff  <= '0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == A_DIV)
        div_ff <= pwdata[DIV_W-1:0];
      hi_ff <= shift_clock_line_out ? hi_ff + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  sequence s_dt_held;
    serial_data_line_oe && $past(serial_data_line_oe);
  endsequence
  property p_half_duplex; serial_data_line_oe |-> shift_clock_line_oe; endproperty
  property p_sync_off; s_wr(A_TXS) ##0 !pwdata[4] |=> !serial_data_line_oe && !shift_clock_line_oe;
  endproperty
  property p_port_off; s_wr(A_RCS) ##0 !pwdata[7] |=> !serial_data_line_oe && !shift_clock_line_oe;
  endproperty
  property p_slave; s_wr(A_TXS) ##0 !pwdata[7] |=> !shift_clock_line_oe; endproperty
  property p_tx_off; s_wr(A_TXS) ##0 !pwdata[5] |=> !serial_data_line_oe; endproperty
  property p_rx_on; s_wr(A_RCS) ##0 (pwdata[5] || pwdata[4]) |=> !serial_data_line_oe; endproperty
  property p_hold; s_dt_held ##0 $fell(shift_clock_line_out) |-> $stable(serial_data_line_out);
  endproperty
  property p_edge; s_dt_held ##0 $changed(serial_data_line_out) |-> $rose(shift_clock_line_out);
  endproperty
  property p_half;
    $fell(shift_clock_line_out) && shift_clock_line_oe && $past(shift_clock_line_oe)
      |-> hi_ff == {1'b0, div_ff} + 1'b1;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("data out without clock");
  a_sync_off: assert property (p_sync_off) else $error("pins kept out of sync mode");
  a_port_off: assert property (p_port_off) else $error("pins kept with port off");
  a_slave: assert property (p_slave) else $error("clock driven as slave");
  a_tx_off: assert property (p_tx_off) else $error("data kept after tx off");
  a_rx_on: assert property (p_rx_on) else $error("data kept in receive");
  a_hold: assert property (p_hold) else $error("data moved at falling clock");
  a_edge: assert property (p_edge) else $error("data moved off rising clock");
  a_half: assert property (p_half) else $error("clock high time wrong");
endmodule
bind sync_master_tx sync_tx_properties #(.DIV_W(DIV_W)) i_sync_tx_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .shift_clock_line_out(shift_clock_line_out), .shift_clock_line_oe(shift_clock_line_oe),
  .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe));
